// ==== qamtl_conv_model.sv ====
// converter model driving the two sample channels
module qamtl_conv_model
  import qamtl_pkg::*;
(
  // clock shared with the converter sampling clock
  input  wire logic                mclk_in,
  // sample channels
  output logic      [SAMPLE_W-1:0] a_out,
  output logic      [SAMPLE_W-1:0] b_out,
  output logic                     valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    a_out = '0;
    b_out = '0;
    valid_out = 1'h0;
  end
  // one sample per cycle on both channels, launched after the edge
  task automatic send(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
    @(posedge mclk_in);
    a_out     <= a;
    b_out     <= b;
    valid_out <= 1'h1;
  endtask : send
  // idle lines flip so stale data can never pass for a fresh sample
  task automatic idle();
    @(posedge mclk_in);
    a_out     <= ~a_out;
    b_out     <= ~b_out;
    valid_out <= 1'h0;
  endtask : idle
endmodule : qamtl_conv_model

// ==== qamtl_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
module qamtl_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_reg;
  logic [PW-1:0]    rd_reg;
  logic [PW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_reg != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out  = mem_reg[rd_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : qamtl_fifo

// ==== qamtl_front.sv ====
// timing lock loop front end with sample path, fifo and wishbone registers
//
// The Wishbone slave port and the register addresses were decided locally.
module qamtl_front
  import qamtl_pkg::*;
#(
  parameter int WIN_SHORT = WIN_SHORT_SYM,
  parameter int WIN_LONG  = WIN_LONG_SYM
) (
  // clock and resets
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  input  wire logic                core_reset_n_in,
  input  wire logic                restart_in,
  input  wire logic                fifo_read_clock_in,
  // sample inputs
  input  wire logic                sample_format_sel_in,
  input  wire logic [SAMPLE_W-1:0] sample_in_a_in,
  input  wire logic [SAMPLE_W-1:0] sample_in_b_in,
  input  wire logic                sample_valid_in,
  output logic                     sample_ready_out,
  // static settings pins
  input  wire logic [7:0]          gain_threshold_ref_in,
  input  wire logic                osc_range_sel_in,
  input  wire logic                costas_gain_sel_in,
  input  wire logic [1:0]          freq_err_gain_prelock_in,
  input  wire logic [1:0]          freq_err_gain_postlock_in,
  input  wire logic                lock_threshold_sel_in,
  input  wire logic                lock_window_sel_in,
  // loop outputs
  output logic [OSC_W-1:0]         osc_control_word_out,
  output logic                     gain_up_out,
  output logic                     gain_down_out,
  output logic                     lock_declared_out,
  output logic                     carrier_active_out,
  // fifo output
  output logic [2*SAMPLE_W-1:0]    fifo_data_out,
  output logic                     fifo_valid_out,
  // wishbone slave
  input  wire logic                wb_cyc_in,
  input  wire logic                wb_stb_in,
  input  wire logic                wb_we_in,
  input  wire logic [7:0]          wb_adr_in,
  input  wire logic [3:0]          wb_sel_in,
  input  wire logic [31:0]         wb_dat_in,
  output logic [31:0]              wb_dat_out,
  output logic                     wb_ack_out
);
  localparam int WIN_W = $clog2(WIN_LONG) + 1;

  // magnitude of a two's complement sample
  function automatic logic [SAMPLE_W-1:0] mag(input logic signed [SAMPLE_W-1:0] v);
    mag = v[SAMPLE_W-1] ? SAMPLE_W'(-v) : SAMPLE_W'(v);
  endfunction : mag

  // convert pin coding to two's complement
  function automatic logic [SAMPLE_W-1:0] to_tc(input logic [SAMPLE_W-1:0] v,
                                                input logic ofs);
    to_tc = ofs ? {~v[SAMPLE_W-1], v[SAMPLE_W-2:0]} : v;
  endfunction : to_tc

  // arithmetic shift of an accumulator by a select-derived amount
  function automatic logic signed [ACC_W-1:0] ashr(input logic signed [ACC_W-1:0] v,
                                                   input int sh);
    ashr = v >>> sh;
  endfunction : ashr

  // ---------------- wishbone registers ----------------
  logic [OVR_W-1:0] ovr_reg;
  logic [SET_W-1:0] set_reg;
  logic             ack_reg;
  logic [31:0]      rdat_reg;
  logic             wb_req;
  logic [31:0]      wmask;
  logic [31:0]      status_word;
  logic [CNT_W-1:0] good_cnt_reg;
  logic [CNT_W-1:0] last_cnt_reg;
  logic             fifo_full;
  logic             fifo_nempty;
  qamtl_carr_e      carr_reg;

  assign wb_req = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign wmask  = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdat_reg;
  assign status_word = {4'h0, osc_control_word_out, 12'h000, fifo_nempty, fifo_full,
                        carr_reg == QAMTL_CARR_ACQ, lock_declared_out};

  always_ff @(posedge mclk_in or negedge core_reset_n_in) begin
    if (!core_reset_n_in) begin
      ovr_reg <= OVR_RESET;
      set_reg <= SET_RESET;
    end else if (rst_in) begin
      ovr_reg <= OVR_RESET;
      set_reg <= SET_RESET;
    end else if (wb_cyc_in && wb_stb_in && ack_reg && wb_we_in) begin // lands on the ack edge
      if (wb_adr_in == REG_OVR_EN) begin
        ovr_reg <= (ovr_reg & ~wmask[OVR_W-1:0]) | (wb_dat_in[OVR_W-1:0] & wmask[OVR_W-1:0]);
      end else if (wb_adr_in == REG_SETTING) begin
        set_reg <= (set_reg & ~wmask[SET_W-1:0]) | (wb_dat_in[SET_W-1:0] & wmask[SET_W-1:0]);
      end
    end
  end

  // single wait state; unmapped reads return zero, writes there are dropped
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req && !wb_we_in) begin
        if (wb_adr_in == REG_OVR_EN) begin
          rdat_reg <= {{(32-OVR_W){1'b0}}, ovr_reg};
        end else if (wb_adr_in == REG_SETTING) begin
          rdat_reg <= {{(32-SET_W){1'b0}}, set_reg};
        end else if (wb_adr_in == REG_STATUS) begin
          rdat_reg <= status_word;
        end else if (wb_adr_in == REG_LOCK_CNT) begin
          rdat_reg <= {{(32-CNT_W){1'b0}}, last_cnt_reg};
        end else begin
          rdat_reg <= 32'h0000_0000;
        end
      end else begin
        rdat_reg <= 32'h0000_0000;
      end
    end
  end

  // ---------------- registered pins and effective settings ----------------
  logic                restart_reg;
  logic                fmt_reg;
  logic [SAMPLE_W-1:0] a_reg;
  logic [SAMPLE_W-1:0] b_reg;
  logic                sv_reg;
  logic [15:0]         pin_set_reg;
  logic [15:0]         eff;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      restart_reg <= 1'b0;
      fmt_reg     <= 1'b0;
      a_reg       <= '0;
      b_reg       <= '0;
      sv_reg      <= 1'b0;
      pin_set_reg <= SET_RESET;
    end else begin
      restart_reg <= restart_in;
      fmt_reg     <= sample_format_sel_in;
      a_reg       <= sample_in_a_in;
      b_reg       <= sample_in_b_in;
      sv_reg      <= sample_valid_in;
      pin_set_reg <= {gain_threshold_ref_in, lock_window_sel_in, lock_threshold_sel_in,
                      freq_err_gain_postlock_in, freq_err_gain_prelock_in,
                      costas_gain_sel_in, osc_range_sel_in};
    end
  end

  always_comb begin
    eff = pin_set_reg;
    if (ovr_reg[OVR_RANGE])   eff[SET_RANGE] = set_reg[SET_RANGE];
    if (ovr_reg[OVR_COSTAS])  eff[SET_COSTAS] = set_reg[SET_COSTAS];
    if (ovr_reg[OVR_PRE])     eff[SET_PRE+:2] = set_reg[SET_PRE+:2];
    if (ovr_reg[OVR_POST])    eff[SET_POST+:2] = set_reg[SET_POST+:2];
    if (ovr_reg[OVR_THR])     eff[SET_THR] = set_reg[SET_THR];
    if (ovr_reg[OVR_WIN])     eff[SET_WIN] = set_reg[SET_WIN];
    if (ovr_reg[OVR_GAINREF]) eff[SET_GAINREF+:8] = set_reg[SET_GAINREF+:8];
  end

  // ---------------- sample path and fifo ----------------
  logic [SAMPLE_W-1:0] a_tc;
  logic [SAMPLE_W-1:0] b_tc;
  logic                rd_level;
  logic                rd_level_d_reg;
  logic                rd_edge;
  logic [2*SAMPLE_W-1:0] fifo_q;

  assign a_tc = to_tc(a_reg, fmt_reg);
  assign b_tc = to_tc(b_reg, fmt_reg);
  assign fifo_full = ~sample_ready_out;
  assign rd_edge = rd_level & ~rd_level_d_reg;

  qamtl_sync u_rdclk_sync (
    .clk_in (mclk_in),
    .rst_in (rst_in),
    .d_in   (fifo_read_clock_in),
    .q_out  (rd_level)
  );

  qamtl_fifo #(
    .WIDTH (2*SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (mclk_in),
    .rst_in        (rst_in),
    .in_valid_in   (sv_reg),
    .in_ready_out  (sample_ready_out),
    .in_data_in    ({a_tc, b_tc}),
    .out_valid_out (fifo_nempty),
    .out_ready_in  (rd_edge),
    .out_data_out  (fifo_q)
  );

  // one word leaves per rising edge of the user read clock
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_level_d_reg <= 1'b0;
      fifo_data_out  <= '0;
      fifo_valid_out <= 1'b0;
    end else begin
      rd_level_d_reg <= rd_level;
      fifo_valid_out <= rd_edge & fifo_nempty;
      if (rd_edge && fifo_nempty) begin
        fifo_data_out <= fifo_q;
      end
    end
  end

  // ---------------- timing detector ----------------
  // symbols come every second sample; phase 1 is the symbol sample
  logic                       ph_reg;
  logic signed [SAMPLE_W-1:0] mid_reg;
  logic signed [SAMPLE_W-1:0] prev_reg;
  logic signed [ACC_W-1:0]    err;
  logic                       sym_stb;
  logic                       loop_clr;

  assign sym_stb  = sv_reg & ph_reg;
  assign loop_clr = rst_in | restart_reg;

  always_comb begin
    err = '0;
    if (prev_reg[SAMPLE_W-1] != a_tc[SAMPLE_W-1]) begin
      err = prev_reg[SAMPLE_W-1] ? -(ACC_W'(mid_reg) <<< ERR_SCALE_SH)
                                 :  (ACC_W'(mid_reg) <<< ERR_SCALE_SH);
    end
  end

  always_ff @(posedge mclk_in or negedge core_reset_n_in) begin
    if (!core_reset_n_in) begin
      ph_reg   <= 1'b0;
      mid_reg  <= '0;
      prev_reg <= '0;
    end else if (loop_clr) begin
      ph_reg   <= 1'b0;
      mid_reg  <= '0;
      prev_reg <= '0;
    end else if (sv_reg) begin
      ph_reg <= ~ph_reg;
      if (ph_reg) begin
        prev_reg <= a_tc;
      end else begin
        mid_reg <= a_tc;
      end
    end
  end

  // ---------------- loop filters and oscillator word ----------------
  logic signed [ACC_W-1:0] costas_reg;
  logic signed [ACC_W-1:0] freq_reg;
  logic signed [ACC_W-1:0] osc_ofs;
  logic signed [ACC_W-1:0] osc_sum;
  int                      c_sh;
  int                      f_sh;

  always_comb begin
    c_sh = eff[SET_COSTAS] ? COSTAS_SH_HI : COSTAS_SH_LO;
    if (lock_declared_out) begin
      f_sh = POST_SH_BASE - int'(eff[SET_POST+:2]);
    end else begin
      f_sh = PRE_SH_BASE - int'(eff[SET_PRE+:2]);
    end
    // a wider range needs less word swing for the same correction
    osc_ofs = ashr(freq_reg, eff[SET_RANGE] ? RANGE_SH_HI : RANGE_SH_LO);
    osc_sum = ACC_W'(OSC_MID) + osc_ofs;
  end

  always_ff @(posedge mclk_in or negedge core_reset_n_in) begin
    if (!core_reset_n_in) begin
      costas_reg           <= '0;
      freq_reg             <= '0;
      osc_control_word_out <= OSC_MID;
    end else if (loop_clr) begin
      costas_reg           <= '0;
      freq_reg             <= '0;
      osc_control_word_out <= OSC_MID;
    end else begin
      if (sym_stb) begin
        costas_reg <= costas_reg + ashr(err - costas_reg, c_sh);
        freq_reg   <= freq_reg + ashr(costas_reg, f_sh);
      end
      // saturate rather than wrap so a runaway loop pins the oscillator at an end
      if (osc_sum < 0) begin
        osc_control_word_out <= '0;
      end else if (osc_sum > ACC_W'({OSC_W{1'b1}})) begin
        osc_control_word_out <= {OSC_W{1'b1}};
      end else begin
        osc_control_word_out <= osc_sum[OSC_W-1:0];
      end
    end
  end

  // ---------------- gain control signalling ----------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      gain_up_out   <= 1'b0;
      gain_down_out <= 1'b0;
    end else if (sym_stb) begin
      gain_up_out   <= (mag(a_tc) >> 2) < SAMPLE_W'(eff[SET_GAINREF+:8]);
      gain_down_out <= (mag(a_tc) >> 2) > SAMPLE_W'(eff[SET_GAINREF+:8]);
    end
  end

  // ---------------- lock detector ----------------
  // a good symbol peaks above its mid sample; an ideal signal scores every symbol
  logic [WIN_W-1:0] win_cnt_reg;
  logic [WIN_W-1:0] win_len;
  logic [WIN_W-1:0] win_thr;
  logic             good_sym;

  assign win_len  = eff[SET_WIN] ? WIN_W'(WIN_LONG) : WIN_W'(WIN_SHORT);
  assign win_thr  = eff[SET_THR] ? (win_len - (win_len >> 2)) : (win_len >> 1);
  assign good_sym = mag(a_tc) > mag(mid_reg);

  always_ff @(posedge mclk_in or negedge core_reset_n_in) begin
    if (!core_reset_n_in) begin
      win_cnt_reg       <= '0;
      good_cnt_reg      <= '0;
      last_cnt_reg      <= '0;
      lock_declared_out <= 1'b0;
    end else if (loop_clr) begin
      win_cnt_reg       <= '0;
      good_cnt_reg      <= '0;
      last_cnt_reg      <= '0;
      lock_declared_out <= 1'b0;
    end else if (sym_stb) begin
      if (win_cnt_reg == win_len - 1'b1) begin
        win_cnt_reg  <= '0;
        good_cnt_reg <= '0;
        last_cnt_reg <= good_cnt_reg + CNT_W'(good_sym);
        if (WIN_W'(good_cnt_reg + CNT_W'(good_sym)) > win_thr) begin
          lock_declared_out <= 1'b1;
        end
      end else begin
        win_cnt_reg  <= win_cnt_reg + 1'b1;
        good_cnt_reg <= good_cnt_reg + CNT_W'(good_sym);
      end
    end
  end

  // ---------------- carrier loop gate ----------------
  always_ff @(posedge mclk_in or negedge core_reset_n_in) begin
    if (!core_reset_n_in) begin
      carr_reg <= QAMTL_CARR_IDLE;
    end else if (loop_clr) begin
      carr_reg <= QAMTL_CARR_IDLE;
    end else begin
      case (carr_reg)
        QAMTL_CARR_IDLE: begin
          if (lock_declared_out) begin
            carr_reg <= QAMTL_CARR_ACQ;
          end
        end
        default: begin
          carr_reg <= QAMTL_CARR_ACQ;
        end
      endcase
    end
  end

  assign carrier_active_out = (carr_reg == QAMTL_CARR_ACQ);
endmodule : qamtl_front

// ==== qamtl_front_chk.sv ====
// port-level assertions for the timing front end
module qamtl_front_chk
  import qamtl_pkg::*;
(
  // clock, resets, restart
  input wire logic             mclk_in,
  input wire logic             rst_in,
  input wire logic             core_reset_n_in,
  input wire logic             restart_in,
  // bus handshake
  input wire logic             wb_cyc_in,
  input wire logic             wb_stb_in,
  input wire logic             wb_ack_out,
  // loop and fifo outputs
  input wire logic             lock_declared_out,
  input wire logic             carrier_active_out,
  input wire logic             gain_up_out,
  input wire logic             gain_down_out,
  input wire logic             fifo_valid_out,
  input wire logic [OSC_W-1:0] osc_control_word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in || !core_reset_n_in);

  property p_ack_next; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus answer late");
  property p_ack_once; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_restart;
    restart_in |-> ##2 (!lock_declared_out && !carrier_active_out && osc_control_word_out == OSC_MID);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear loop");
  property p_carr_lock; carrier_active_out |-> lock_declared_out; endproperty
  a_carr_lock: assert property (p_carr_lock) else $error("carrier active without lock");
  property p_carr_rise; $rose(lock_declared_out) |=> carrier_active_out; endproperty
  a_carr_rise: assert property (p_carr_rise) else $error("carrier not enabled");
  // restart acts one edge late, so both the current and previous level are excluded
  property p_sticky;
    lock_declared_out && !restart_in && !$past(restart_in) |=> lock_declared_out;
  endproperty
  a_sticky: assert property (p_sticky) else $error("lock dropped on its own");
  property p_core;
    disable iff (rst_in)
    !core_reset_n_in |-> !lock_declared_out && !carrier_active_out && osc_control_word_out == OSC_MID;
  endproperty
  a_core: assert property (p_core) else $error("async reset did not clear");
  property p_gain; !(gain_up_out && gain_down_out); endproperty
  a_gain: assert property (p_gain) else $error("gain up and down together");
  property p_rd_gap; fifo_valid_out |=> !fifo_valid_out; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read pulse too long");
endmodule : qamtl_front_chk

bind qamtl_front qamtl_front_chk i_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .core_reset_n_in(core_reset_n_in),
  .restart_in(restart_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_ack_out(wb_ack_out), .lock_declared_out(lock_declared_out),
  .carrier_active_out(carrier_active_out), .gain_up_out(gain_up_out),
  .gain_down_out(gain_down_out), .fifo_valid_out(fifo_valid_out),
  .osc_control_word_out(osc_control_word_out));

// ==== qamtl_front_tb.sv ====
// self-checking bench for the timing front end
module qamtl_front_tb
  import qamtl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, crn = 1, rs = 0, rck = 0, fmt = 0, sv, rdy, ack, got;
  logic rng = 0, cos = 0, thr = 0, win = 0, cyc = 0, stb = 0, we = 0;
  logic gup, gdn, lck, car, fv;
  logic [SAMPLE_W-1:0] sa, sb, pa, pb;
  logic [7:0] ref_p = 8'h00, adr = 8'h00;
  logic [1:0] pre = 2'h0, post = 2'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = '0, rdat, rd;
  logic [OSC_W-1:0] osc;
  logic [19:0] fd, got_d;
  logic [19:0] q[$];
  int bad_count = 0, cmp_count = 0, n;

  always #50 clk = ~clk; // one clock for bench and converter

  qamtl_front #(.WIN_SHORT(16), .WIN_LONG(32)) i_dut (
    .mclk_in(clk), .rst_in(rst), .core_reset_n_in(crn), .restart_in(rs),
    .fifo_read_clock_in(rck), .sample_format_sel_in(fmt), .sample_in_a_in(sa),
    .sample_in_b_in(sb), .sample_valid_in(sv), .sample_ready_out(rdy),
    .gain_threshold_ref_in(ref_p), .osc_range_sel_in(rng), .costas_gain_sel_in(cos),
    .freq_err_gain_prelock_in(pre), .freq_err_gain_postlock_in(post),
    .lock_threshold_sel_in(thr), .lock_window_sel_in(win), .osc_control_word_out(osc),
    .gain_up_out(gup), .gain_down_out(gdn), .lock_declared_out(lck),
    .carrier_active_out(car), .fifo_data_out(fd), .fifo_valid_out(fv), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack));
  qamtl_conv_model i_conv (.mclk_in(clk), .a_out(sa), .b_out(sb), .valid_out(sv));

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    @(posedge clk);
    // only the watchdog ends a wait for the answer
    while (ack !== 1'h1) @(posedge clk);
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, '0);
    check(rd, e);
  endtask : rdchk

  // one read clock period, slow enough for the pin filter
  task automatic pop(output logic g, output logic [19:0] d);
    g = 1'h0;
    d = '0;
    @(posedge clk) rck <= 1'h1;
    repeat (8) begin
      @(posedge clk);
      if (fv === 1'h1) begin
        g = 1'h1;
        d = fd;
      end
    end
    rck <= 1'h0;
    repeat (5) @(posedge clk);
  endtask : pop

  // good8 of every eight symbols peak above their mid sample
  task automatic lockwait(input int good8, input int lim);
    n = 0;
    while (lck !== 1'h1 && n < lim) begin
      i_conv.send(10'($urandom_range(100, 115)), 10'h000);
      if ((n / 2) % 8 < good8) i_conv.send(10'($urandom_range(300, 400)), 10'h000);
      else i_conv.send(10'($urandom_range(0, 15)), 10'h000);
      n += 2;
    end
    i_conv.idle();
  endtask : lockwait

  function automatic logic [9:0] to_tc(input logic [9:0] p, input logic f);
    return f ? p ^ 10'h200 : p;
  endfunction : to_tc

  initial begin
    void'($urandom(10));
    {rng, cos, pre, post} <= 6'($urandom);
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rdchk(REG_OVR_EN, '0);
    rdchk(REG_SETTING, '0);
    rdchk(REG_STATUS, {4'h0, OSC_MID, 16'h0000});
    wb(1'h1, 8'h40, 32'hffff_ffff);
    rdchk(8'h40, '0);
    for (int f = 0; f < 2; f++) begin
      fmt <= f[0];
      for (int i = 0; i < 9; i++) begin
        {pa, pb} = 20'($urandom);
        i_conv.send(pa, pb);
        if (i < 8) q.push_back({to_tc(pa, f[0]), to_tc(pb, f[0])});
      end
      i_conv.idle();
      repeat (2) @(posedge clk);
      check(rdy, 1'h0);
      while (q.size() > 0) begin
        pop(got, got_d);
        check({got, got_d}, {1'h1, q.pop_front()});
      end
      pop(got, got_d);
      check(got, 1'h0);
      check(rdy, 1'h1);
    end
    repeat (6) i_conv.send(10'h100, 10'h100);
    i_conv.idle();
    repeat (4) @(posedge clk);
    check({gup, gdn}, 2'h1);
    wb(1'h1, REG_SETTING, 32'h0000_ff00);
    wb(1'h1, REG_OVR_EN, 32'h0000_0040);
    rdchk(REG_SETTING, 32'h0000_ff00);
    rdchk(REG_OVR_EN, 32'h0000_0040);
    repeat (6) i_conv.send(10'h100, 10'h100);
    i_conv.idle();
    repeat (4) @(posedge clk);
    check({gup, gdn}, 2'h2);
    #30 crn = 1'h0;
    #10;
    check({lck, car, osc}, {2'h0, OSC_MID});
    @(posedge clk) crn <= 1'h1;
    rdchk(REG_OVR_EN, '0);
    fmt <= 1'h0;
    thr <= 1'($urandom);
    win <= 1'($urandom);
    lockwait(8, 600);
    check(lck, 1'h1);
    check(n >= (win ? 64 : 32), 1'h1);
    rdchk(REG_LOCK_CNT, win ? 32 : 16);
    check(car, 1'h1);
    // five good in eight clears the half threshold but not three quarters
    for (int t = 0; t < 2; t++) begin
      rs <= 1'h1;
      @(posedge clk) rs <= 1'h0;
      repeat (3) @(posedge clk);
      check({lck, car, osc}, {2'h0, OSC_MID});
      lockwait(5, 200);
      check(lck, !thr);
      rdchk(REG_LOCK_CNT, win ? 20 : 10);
      thr <= ~thr;
    end
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule : qamtl_front_tb

// ==== qamtl_pkg.sv ====
// constants and register map of the demodulator timing front end
package qamtl_pkg;
  localparam int SAMPLE_W = 10;
  localparam int OSC_W    = 12;
  localparam int ACC_W    = 24;
  localparam int CNT_W    = 17;
  localparam int FIFO_DEPTH = 8;

  // wishbone register byte offsets
  localparam logic [7:0] REG_OVR_EN = 8'h00;
  localparam logic [7:0] REG_SETTING = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LOCK_CNT = 8'h0c;

  // override enable bits and setting field positions
  localparam int OVR_RANGE   = 0;
  localparam int OVR_COSTAS  = 1;
  localparam int OVR_PRE     = 2;
  localparam int OVR_POST    = 3;
  localparam int OVR_THR     = 4;
  localparam int OVR_WIN     = 5;
  localparam int OVR_GAINREF = 6;
  localparam int OVR_W       = 7;
  localparam int SET_RANGE   = 0;
  localparam int SET_COSTAS  = 1;
  localparam int SET_PRE     = 2;
  localparam int SET_POST    = 4;
  localparam int SET_THR     = 6;
  localparam int SET_WIN     = 7;
  localparam int SET_GAINREF = 8;
  localparam int SET_W       = 16;
  localparam int ST_OSC      = 16;

  localparam logic [OVR_W-1:0] OVR_RESET = 7'h00;
  localparam logic [SET_W-1:0] SET_RESET = 16'h0000;
  localparam logic [OSC_W-1:0] OSC_MID   = 12'h800;

  // filter shifts: gain 1/2^n, except ERR_SCALE_SH, which scales the error up by 2^n
  localparam int COSTAS_SH_LO = 5;
  localparam int COSTAS_SH_HI = 4;
  localparam int PRE_SH_BASE  = 11;
  localparam int POST_SH_BASE = 14;
  localparam int RANGE_SH_LO  = 13;
  localparam int RANGE_SH_HI  = 12;
  localparam int ERR_SCALE_SH = 8;

  // lock window sizes in symbols
  localparam int WIN_SHORT_SYM = 16384;
  localparam int WIN_LONG_SYM  = 32768;

  typedef enum logic [0:0] {QAMTL_CARR_IDLE, QAMTL_CARR_ACQ} qamtl_carr_e;
endpackage : qamtl_pkg

// ==== qamtl_sync.sv ====
// three-stage synchroniser with agreement filter for a pin input
module qamtl_sync (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // async pin and filtered level
  input  wire logic d_in,
  output logic      q_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_out <= s3_reg;
      end
    end
  end
endmodule : qamtl_sync
